// ### inc/btc_pkg.sv
package btc_pkg;
    // Register indices; printed offsets are not all multiples of four,
    // so each printed offset is an index and the byte address is four times it.
    localparam logic [7:0] IDX_WDOG = 8'h00;
    localparam logic [7:0] IDX_ANA0 = 8'h01;
    localparam logic [7:0] IDX_ANA1 = 8'h02;
    localparam logic [7:0] IDX_ASTAT = 8'h03;
    localparam logic [7:0] IDX_UNDEF = 8'h04;
    localparam logic [7:0] IDX_REV = 8'h05;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h08;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h09;
    localparam logic [7:0] IDX_CRC_CTRL = 8'h0A;
    localparam logic [7:0] IDX_CRC_DATA = 8'h0B;
    localparam logic [7:0] IDX_CRC_VAL = 8'h0C;
    localparam logic [7:0] IDX_POLL_DATA = 8'h0D;
    localparam logic [7:0] IDX_POLL_CTRL = 8'h0E;
    localparam logic [7:0] IDX_POLL_STAT = 8'h0F;

    localparam logic [7:0] WDOG_RST = 8'h0F;
    localparam logic [7:0] WDOG_MASK = 8'h8F;
    localparam int WDOG_EN_BIT = 7;
    localparam logic [7:0] ANA0_RST = 8'h74;
    localparam logic [7:0] ANA0_MASK = 8'h7F;
    localparam int ANA0_HV_BIT = 6;
    localparam int ANA0_AUX_BIT = 5;
    localparam int ANA0_CLK_BIT = 4;
    localparam int ANA0_TXM_BIT = 3;
    localparam logic [7:0] ANA1_RST = 8'h60;
    localparam logic [7:0] ANA1_MASK = 8'h7E;
    localparam logic [7:0] REV_ID = 8'h5A; // Arbitrary value

    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_XOROUT = 16'h0000;

    localparam int IRQ_WDOG_BIT = 0;
    localparam int IRQ_POLL_BIT = 1;
    localparam logic [1:0] IRQ_MASK_W = 2'h3;

    localparam int CLK_HZ = 40_000_000;
    // 32.8 ms expressed in microseconds; each code step adds one unit
    localparam int WDOG_UNIT_US = 32_800;
    localparam int WDOG_UNIT_CYC = WDOG_UNIT_US * (CLK_HZ / 1_000_000);
    localparam int POLL_DEPTH = 16;
endpackage

// ### hdl/btc_frame_mem.sv
`timescale 1ns/1ps
module btc_frame_mem (
    input wire logic mclk_i,
    input wire logic ce_i,
    input wire logic we_i,
    input wire logic [3:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [3:0] raddr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:15];

    always_ff @(posedge mclk_i) begin
        if (ce_i) begin
            if (we_i) begin
                mem[waddr_i] <= wdata_i;
            end
            rdata_o <= mem[raddr_i];
        end
    end
endmodule

// ### hdl/btc_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - A complete polling frame loaded by the host is sent byte by byte onto the bus.
// - The frame check is a 16-bit CRC with generator polynomial 0x1021.
// - The check register is preset to 0xFFFF per frame and no final XOR is applied.
// - Neither input bytes nor the output value are bit-reversed.
// - Over ASCII 1 to 9 the check value comes out as 0x29B1.
// - Five byte registers sit at indices 0x00, 0x01, 0x02, 0x03 and 0x05.
// - Watchdog control holds enable in bit 7, timeout code in bits 3..0, 6..4 reserved.
// - Writing 0 to the watchdog enable disables it and writing 1 enables it.
// - Timeout code n selects a period of (n+1) times 32.8 ms.
// - An enabled watchdog that expires without re-enable raises an event.
// - Analog control 0 holds regulator, converter, clock, monitor enables and limit code.
// - Out of reset the monitor is off, regulators and clock on, limit code 100.
// - With monitor enable set the monitor pin drives tx activity, otherwise it floats.
// - Regulator, converter and clock enables switch their function off at 0, on at 1.
module btc_regs
    import btc_pkg::*;
#(
    parameter int WDOG_UNIT_CYCLES = btc_pkg::WDOG_UNIT_CYC
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [7:0] analog_status_i,
    input wire logic tx_activity_i,
    input wire logic bus_tx_ready_i,
    output logic bus_tx_valid_o,
    output logic [7:0] bus_tx_data_o,
    output logic bus_tx_last_o,
    output logic hv_regulator_enable_o,
    output logic aux_converter_enable_o,
    output logic clock_out_enable_o,
    output logic [2:0] hv_current_limit_code_o,
    output logic [2:0] analog_out_select_o,
    output logic [2:0] monitor_mask_o,
    output logic tx_monitor_pin_o,
    output logic tx_monitor_pin_oe_o,
    output logic watchdog_event_o,
    output logic irq_o
);
    import btc_pkg::*;

    typedef enum logic [2:0] {
        BTC_P_IDLE = 3'b001,
        BTC_P_READ = 3'b010,
        BTC_P_SEND = 3'b100
    } btc_poll_e;

    logic [7:0] wdog_q;
    logic [7:0] ana0_q;
    logic [7:0] ana1_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic [15:0] crc_q;
    logic [31:0] wdog_cnt_q;
    logic [3:0] poll_wptr_q;
    logic [3:0] poll_len_q;
    logic [3:0] poll_rptr_q;
    btc_poll_e poll_state_q;
    logic [7:0] mem_rdata;
    logic wr_en;
    logic rd_en;
    logic wdog_fire;
    logic poll_done;
    logic poll_busy;
    logic mem_we;
    logic [31:0] wdog_limit;
    logic [3:0] mem_raddr;
    logic poll_full_q;

    // Index of a byte address; low two bits select nothing
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] idx);
        return addr == {idx[5:0], 2'b00};
    endfunction

    // One byte of MSB-first CRC, polynomial 0x1021, no reflection
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {data, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // Zero-wait slave: setup cycle then access with pready high
    assign wr_en = psel_i & penable_i & pwrite_i & ce_i;
    assign rd_en = psel_i & ~penable_i & ~pwrite_i & ce_i;
    assign poll_busy = poll_state_q != BTC_P_IDLE;
    assign mem_we = wr_en & hit(paddr_i, IDX_POLL_DATA) & ~poll_busy & ~poll_full_q;
    // (n+1) units of 32.8 ms
    assign wdog_limit = WDOG_UNIT_CYCLES * ({28'h0, wdog_q[3:0]} + 32'h1);
    assign wdog_fire = wdog_q[WDOG_EN_BIT] && (wdog_cnt_q >= wdog_limit - 32'h1);
    assign poll_done = (poll_state_q == BTC_P_SEND) && bus_tx_ready_i && bus_tx_last_o;
    // Address the next byte one cycle early, since the memory read is registered
    assign mem_raddr = !poll_busy ? 4'h0
        : poll_rptr_q + {3'h0, poll_state_q == BTC_P_SEND && bus_tx_ready_i};

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (ce_i) begin
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            prdata_o <= 32'h0;
        end else if (rd_en) begin
            if (hit(paddr_i, IDX_WDOG)) begin
                prdata_o <= {24'h0, wdog_q};
            end else if (hit(paddr_i, IDX_ANA0)) begin
                prdata_o <= {24'h0, ana0_q};
            end else if (hit(paddr_i, IDX_ANA1)) begin
                prdata_o <= {24'h0, ana1_q};
            end else if (hit(paddr_i, IDX_ASTAT)) begin
                prdata_o <= {24'h0, 1'b0, analog_status_i[6:0]};
            end else if (hit(paddr_i, IDX_REV)) begin
                prdata_o <= {24'h0, REV_ID};
            end else if (hit(paddr_i, IDX_IRQ_STAT)) begin
                prdata_o <= {30'h0, irq_stat_q};
            end else if (hit(paddr_i, IDX_IRQ_MASK)) begin
                prdata_o <= {30'h0, irq_mask_q};
            end else if (hit(paddr_i, IDX_CRC_VAL)) begin
                prdata_o <= {16'h0, crc_q ^ CRC_XOROUT};
            end else if (hit(paddr_i, IDX_POLL_STAT)) begin
                prdata_o <= {23'h0, poll_busy, poll_len_q, poll_wptr_q};
            end else begin
                prdata_o <= 32'h0;
            end
        end
    end

    // Reserved bits are masked on write so they always read zero
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wdog_q <= WDOG_RST;
        end else if (wr_en && hit(paddr_i, IDX_WDOG)) begin
            wdog_q <= pwdata_i[7:0] & WDOG_MASK;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ana0_q <= ANA0_RST;
        end else if (wr_en && hit(paddr_i, IDX_ANA0)) begin
            ana0_q <= pwdata_i[7:0] & ANA0_MASK;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ana1_q <= ANA1_RST;
        end else if (wr_en && hit(paddr_i, IDX_ANA1)) begin
            ana1_q <= pwdata_i[7:0] & ANA1_MASK;
        end
    end

    // Any write to the control word restarts the period, the refresh
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wdog_cnt_q <= 32'h0;
        end else if (ce_i) begin
            if (!wdog_q[WDOG_EN_BIT] || (wr_en && hit(paddr_i, IDX_WDOG)) || wdog_fire) begin
                wdog_cnt_q <= 32'h0;
            end else begin
                wdog_cnt_q <= wdog_cnt_q + 32'h1;
            end
        end
    end

    // One-cycle pulse; a refresh in the expiry cycle wins
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            watchdog_event_o <= 1'b0;
        end else if (ce_i) begin
            watchdog_event_o <= wdog_fire & ~(wr_en && hit(paddr_i, IDX_WDOG));
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_stat_q <= 2'h0;
        end else if (ce_i) begin
            irq_stat_q <= (irq_stat_q
                & ~((wr_en && hit(paddr_i, IDX_IRQ_STAT)) ? pwdata_i[1:0] : 2'h0))
                | {poll_done, wdog_fire & ~(wr_en && hit(paddr_i, IDX_WDOG))};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_mask_q <= 2'h0;
        end else if (wr_en && hit(paddr_i, IDX_IRQ_MASK)) begin
            irq_mask_q <= pwdata_i[1:0] & IRQ_MASK_W;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Software CRC engine: bit 0 of the control word presets, data feeds one byte
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            crc_q <= CRC_INIT;
        end else if (wr_en && hit(paddr_i, IDX_CRC_CTRL) && pwdata_i[0]) begin
            crc_q <= CRC_INIT;
        end else if (wr_en && hit(paddr_i, IDX_CRC_DATA)) begin
            crc_q <= crc_byte(crc_q, pwdata_i[7:0]);
        end
    end

    // Polling frame loader; writes while sending are dropped
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            poll_wptr_q <= 4'h0;
        end else if (ce_i) begin
            if (poll_done) begin
                poll_wptr_q <= 4'h0;
            end else if (mem_we) begin
                poll_wptr_q <= poll_wptr_q + 4'h1;
            end
        end
    end

    // The sixteenth byte wraps the pointer, so a flag tells a full buffer from an empty one
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            poll_full_q <= 1'b0;
        end else if (ce_i) begin
            if (poll_done) begin
                poll_full_q <= 1'b0;
            end else if (mem_we && poll_wptr_q == 4'hF) begin
                poll_full_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            poll_state_q <= BTC_P_IDLE;
            poll_len_q <= 4'h0;
            poll_rptr_q <= 4'h0;
        end else if (ce_i) begin
            case (poll_state_q)
                BTC_P_IDLE: begin
                    if (wr_en && hit(paddr_i, IDX_POLL_CTRL) && pwdata_i[0]
                        && (poll_wptr_q != 4'h0 || poll_full_q)) begin
                        poll_len_q <= poll_wptr_q - 4'h1;
                        poll_rptr_q <= 4'h0;
                        poll_state_q <= BTC_P_READ;
                    end
                end
                BTC_P_READ: begin
                    poll_state_q <= BTC_P_SEND;
                end
                BTC_P_SEND: begin
                    if (bus_tx_ready_i) begin
                        if (bus_tx_last_o) begin
                            poll_state_q <= BTC_P_IDLE;
                        end else begin
                            poll_rptr_q <= poll_rptr_q + 4'h1;
                            poll_state_q <= BTC_P_READ;
                        end
                    end
                end
                default: begin
                    poll_state_q <= BTC_P_IDLE;
                end
            endcase
        end
    end

    // A byte stays on the stream until the sink takes it
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            bus_tx_valid_o <= 1'b0;
            bus_tx_data_o <= 8'h00;
            bus_tx_last_o <= 1'b0;
        end else if (ce_i) begin
            if (poll_state_q == BTC_P_READ) begin
                bus_tx_valid_o <= 1'b1;
                bus_tx_data_o <= mem_rdata;
                bus_tx_last_o <= poll_rptr_q == poll_len_q;
            end else if (poll_state_q == BTC_P_SEND && bus_tx_ready_i) begin
                bus_tx_valid_o <= 1'b0;
                bus_tx_last_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hv_regulator_enable_o <= ANA0_RST[ANA0_HV_BIT];
            aux_converter_enable_o <= ANA0_RST[ANA0_AUX_BIT];
            clock_out_enable_o <= ANA0_RST[ANA0_CLK_BIT];
            hv_current_limit_code_o <= ANA0_RST[2:0];
            analog_out_select_o <= ANA1_RST[3:1];
            monitor_mask_o <= ANA1_RST[6:4];
            tx_monitor_pin_o <= 1'b0;
            tx_monitor_pin_oe_o <= 1'b0;
        end else if (ce_i) begin
            hv_regulator_enable_o <= ana0_q[ANA0_HV_BIT];
            aux_converter_enable_o <= ana0_q[ANA0_AUX_BIT];
            clock_out_enable_o <= ana0_q[ANA0_CLK_BIT];
            hv_current_limit_code_o <= ana0_q[2:0];
            analog_out_select_o <= ana1_q[3:1];
            monitor_mask_o <= ana1_q[6:4];
            tx_monitor_pin_o <= ana0_q[ANA0_TXM_BIT] & tx_activity_i;
            tx_monitor_pin_oe_o <= ana0_q[ANA0_TXM_BIT];
        end
    end

    btc_frame_mem u_mem (
        .mclk_i(mclk_i),
        .ce_i(ce_i),
        .we_i(mem_we),
        .waddr_i(poll_wptr_q),
        .wdata_i(pwdata_i[7:0]),
        .raddr_i(mem_raddr),
        .rdata_o(mem_rdata)
    );
endmodule

// ### testbench/btc_regs_sva.sv
`timescale 1ns/1ps
module btc_regs_sva (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic tx_activity_i,
    input wire logic bus_tx_ready_i,
    input wire logic bus_tx_valid_o,
    input wire logic [7:0] bus_tx_data_o,
    input wire logic bus_tx_last_o,
    input wire logic hv_regulator_enable_o,
    input wire logic aux_converter_enable_o,
    input wire logic clock_out_enable_o,
    input wire logic [2:0] hv_current_limit_code_o,
    input wire logic tx_monitor_pin_o,
    input wire logic tx_monitor_pin_oe_o,
    input wire logic watchdog_event_o
);
    import btc_pkg::*;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    logic rd_acc;
    logic wr_acc;
    assign rd_acc = psel_i && penable_i && pready_o && !pwrite_i;
    assign wr_acc = psel_i && penable_i && pready_o && pwrite_i && ce_i;
    ready_setup_a: assert property (psel_i && !penable_i && ce_i |=> pready_o)
        else $error("no ready after setup");
    undef_zero_a: assert property (rd_acc && paddr_i == 8'h10 |-> prdata_o == 32'h0)
        else $error("undefined place reads nonzero");
    wdog_rsvd_a: assert property (rd_acc && paddr_i == 8'h00 |->
        prdata_o[31:8] == 24'h0 && prdata_o[6:4] == 3'h0)
        else $error("watchdog reserved bits set");
    ana0_rsvd_a: assert property (rd_acc && paddr_i == 8'h04 |-> prdata_o[31:7] == 25'h0)
        else $error("analog reserved bit set");
    ana0_write_a: assert property (wr_acc && paddr_i == 8'h04 |=> ##1
        {hv_regulator_enable_o, aux_converter_enable_o, clock_out_enable_o,
        tx_monitor_pin_oe_o, hv_current_limit_code_o} == $past(pwdata_i[6:0], 2))
        else $error("analog outputs do not follow write");
    out_reset_a: assert property ($past(sys_rst_i) |-> hv_regulator_enable_o &&
        aux_converter_enable_o && clock_out_enable_o && hv_current_limit_code_o == 3'h4 &&
        !tx_monitor_pin_oe_o && !tx_monitor_pin_o)
        else $error("outputs wrong after reset");
    mon_follow_a: assert property (tx_monitor_pin_oe_o && $past(tx_monitor_pin_oe_o) |->
        tx_monitor_pin_o == $past(tx_activity_i))
        else $error("monitor pin does not follow activity");
    wdog_pulse_a: assert property (watchdog_event_o |=> !watchdog_event_o)
        else $error("watchdog event longer than one cycle");
    tx_hold_a: assert property (bus_tx_valid_o && !bus_tx_ready_i |=> bus_tx_valid_o &&
        $stable(bus_tx_data_o) && $stable(bus_tx_last_o))
        else $error("frame byte dropped while stalled");
endmodule
bind btc_regs btc_regs_sva u_sva (.mclk_i, .sys_rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .tx_activity_i, .bus_tx_ready_i,
    .bus_tx_valid_o, .bus_tx_data_o, .bus_tx_last_o, .hv_regulator_enable_o,
    .aux_converter_enable_o, .clock_out_enable_o, .hv_current_limit_code_o,
    .tx_monitor_pin_o, .tx_monitor_pin_oe_o, .watchdog_event_o);

// ### testbench/btc_tx_sink.sv
`timescale 1ns/1ps
module btc_tx_sink (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic valid_i,
    input wire logic [7:0] data_i,
    input wire logic last_i,
    output logic ready_o,
    output logic [7:0] got_o [16],
    output logic [15:0] last_o,
    output logic [4:0] count_o
);
    logic [1:0] ph_q;
    // Stall one cycle in three so the sender must hold its byte
    assign ready_o = (ph_q != 2'h0);
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ph_q <= 2'h0;
            count_o <= 5'h0;
            last_o <= 16'h0;
        end else begin
            ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
            if (valid_i && ready_o && count_o < 5'h10) begin
                got_o[count_o[3:0]] <= data_i;
                last_o[count_o[3:0]] <= last_i;
                count_o <= count_o + 5'h1;
            end
        end
    end
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import btc_pkg::*;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [7:0] analog_status_i = 8'h00;
    logic tx_activity_i = 1'b0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, bus_tx_ready_i, bus_tx_valid_o, bus_tx_last_o;
    logic [7:0] bus_tx_data_o;
    logic hv_regulator_enable_o, aux_converter_enable_o, clock_out_enable_o;
    logic [2:0] hv_current_limit_code_o, analog_out_select_o, monitor_mask_o;
    logic tx_monitor_pin_o, tx_monitor_pin_oe_o, watchdog_event_o, irq_o;
    logic [7:0] got [16];
    logic [15:0] lastv;
    logic [4:0] cnt;
    int err_total = 0;
    int checked = 0;
    btc_regs #(.WDOG_UNIT_CYCLES(20)) u_dut (.mclk_i, .sys_rst_i, .ce_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .analog_status_i,
        .tx_activity_i, .bus_tx_ready_i, .bus_tx_valid_o, .bus_tx_data_o, .bus_tx_last_o,
        .hv_regulator_enable_o, .aux_converter_enable_o, .clock_out_enable_o,
        .hv_current_limit_code_o, .analog_out_select_o, .monitor_mask_o, .tx_monitor_pin_o,
        .tx_monitor_pin_oe_o, .watchdog_event_o, .irq_o);
    btc_tx_sink u_sink (.mclk_i, .sys_rst_i, .valid_i(bus_tx_valid_o), .data_i(bus_tx_data_o),
        .last_i(bus_tx_last_o), .ready_o(bus_tx_ready_i), .got_o(got), .last_o(lastv),
        .count_o(cnt));
    initial forever #12.5 mclk_i = ~mclk_i;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge mclk_i);
        end while (pready_o !== 1'b1);
        q = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(what, q, exp);
    endtask
    task automatic pins(input logic [6:0] exp);
        chk("analog pins", {hv_regulator_enable_o, aux_converter_enable_o, clock_out_enable_o,
            tx_monitor_pin_oe_o, hv_current_limit_code_o}, exp);
    endtask
    task automatic t_reset();
        rdc("wdog rst", 8'h00, 32'h0F);
        rdc("ana0 rst", 8'h04, 32'h74);
        rdc("ana1 rst", 8'h08, 32'h60);
        rdc("undef", 8'h10, 32'h0);
        rdc("rev", 8'h14, {24'h0, REV_ID});
        pins(7'h74);
        chk("mon pin", tx_monitor_pin_o, 1'b0);
        chk("ana1 pins", {monitor_mask_o, analog_out_select_o}, 6'h30);
        chk("slverr", pslverr_o, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_regs();
        wr(8'h04, 32'hFF);
        rdc("ana0 rsvd", 8'h04, 32'h7F);
        pins(7'h7F);
        tx_activity_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk("mon high", tx_monitor_pin_o, 1'b1);
        wr(8'h04, 32'h00);
        @(posedge mclk_i);
        pins(7'h00);
        chk("mon off", {tx_monitor_pin_oe_o, tx_monitor_pin_o}, 2'h0);
        tx_activity_i <= 1'b0;
        wr(8'h00, 32'hF5);
        rdc("wdog rsvd", 8'h00, 32'h85);
        wr(8'h00, 32'h70);
        rdc("wdog clear", 8'h00, 32'h00);
        wr(8'h08, 32'hFF);
        rdc("ana1 rsvd", 8'h08, 32'h7E);
        chk("ana1 pins", {monitor_mask_o, analog_out_select_o}, 6'h3F);
        analog_status_i <= 8'hFF;
        rdc("astat", 8'h0C, 32'h7F);
        wr(8'h14, 32'h00);
        rdc("rev ro", 8'h14, {24'h0, REV_ID});
        $display("test regs done");
    endtask
    task automatic t_crc();
        string s;
        s = "123456789";
        wr(8'h28, 32'h1);
        foreach (s[i]) wr(8'h2C, {24'h0, s[i]});
        rdc("crc check", 8'h30, 32'h29B1);
        wr(8'h2C, 32'h29);
        wr(8'h2C, 32'hB1);
        rdc("crc residue", 8'h30, 32'h0000);
        wr(8'h28, 32'h1);
        rdc("crc preset", 8'h30, 32'hFFFF);
        $display("test crc done");
    endtask
    task automatic t_wdog();
        int n;
        wr(8'h24, 32'h0);
        wr(8'h20, 32'h3);
        wr(8'h00, 32'h81);
        repeat (30) @(posedge mclk_i);
        // Refresh well before the 40-cycle period runs out
        wr(8'h00, 32'h81);
        n = 0;
        while (watchdog_event_o !== 1'b1 && n < 100) begin
            @(posedge mclk_i);
            n++;
        end
        chk("wdog period", 32'(n >= 36 && n <= 42), 32'h1);
        repeat (2) @(posedge mclk_i);
        chk("irq masked", irq_o, 1'b0);
        rdc("irq status", 8'h20, 32'h1);
        wr(8'h24, 32'h1);
        repeat (2) @(posedge mclk_i);
        chk("irq on", irq_o, 1'b1);
        wr(8'h20, 32'h1);
        wr(8'h00, 32'h01);
        repeat (2) @(posedge mclk_i);
        chk("irq cleared", irq_o, 1'b0);
        n = 0;
        repeat (120) begin
            @(posedge mclk_i);
            if (watchdog_event_o !== 1'b0) n++;
        end
        chk("wdog off", n, 0);
        $display("test watchdog done");
    endtask
    task automatic t_poll();
        logic [7:0] b [3];
        int n;
        b = '{8'hA5, 8'h3C, 8'h0F};
        wr(8'h24, 32'h3);
        wr(8'h20, 32'h3);
        foreach (b[i]) wr(8'h34, {24'h0, b[i]});
        wr(8'h38, 32'h1);
        n = 0;
        while (cnt !== 5'h3 && n < 200) begin
            @(posedge mclk_i);
            n++;
        end
        repeat (4) @(posedge mclk_i);
        chk("frame len", cnt, 5'h3);
        foreach (b[i]) chk("frame byte", got[i], b[i]);
        chk("frame last", lastv, 16'h4);
        rdc("sent status", 8'h20, 32'h2);
        rdc("poll status", 8'h3C, 32'h20);
        chk("sent irq", irq_o, 1'b1);
        $display("test poll done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        err_total++;
        results();
    end
    initial begin
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        t_reset();
        t_regs();
        t_crc();
        t_wdog();
        t_poll();
        results();
    end
endmodule
